// *** bench/ctsu_pad_model.sv ***
// two touch pads with sense oscillators plus the reference oscillator
`timescale 1ns/1ps
module ctsu_pad_model (
    input wire logic ref_osc_en,
    input wire logic [1:0] sense_osc_en,
    input wire logic [1:0] pad_out,
    input wire logic [1:0] pad_oe,
    output logic ref_osc_clk,
    output logic [1:0] sense_osc_clk,
    output logic [1:0] pad_in
);
    // ----------------------------------------
    // oscillators stand low while disabled; edges land on falling sys_clk edges
    // ----------------------------------------
    initial begin
        ref_osc_clk = 1'b0;
        sense_osc_clk = 2'b00;
    end
    always begin
        if (ref_osc_en === 1'b1) #100 ref_osc_clk = ~ref_osc_clk;
        else begin
            ref_osc_clk = 1'b0;
            @(ref_osc_en);
            #10;
        end
    end
    // each pad free-running at its own rate
    always begin
        if (sense_osc_en[0] === 1'b1) #100 sense_osc_clk[0] = ~sense_osc_clk[0];
        else begin
            sense_osc_clk[0] = 1'b0;
            @(sense_osc_en);
            #10;
        end
    end
    always begin
        if (sense_osc_en[1] === 1'b1) #140 sense_osc_clk[1] = ~sense_osc_clk[1];
        else begin
            sense_osc_clk[1] = 1'b0;
            @(sense_osc_en);
            #10;
        end
    end
    // pins pulled up when nobody drives them
    assign pad_in[0] = pad_oe[0] ? pad_out[0] : 1'b1;
    assign pad_in[1] = pad_oe[1] ? pad_out[1] : 1'b1;
endmodule

// *** bench/ctsu_top_tb.sv ***
// self-checking bench for the touch scan unit
`timescale 1ns/1ps
module ctsu_top_tb;
    import ctsu_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    logic ack, ref_clk, ref_en, irq_req, irq;
    logic [1:0] sense_clk, sense_en, pad_in, pad_out, pad_oe, gin;
    logic [1:0] gout = 2'b00, goe = 2'b00;
    int fail_count = 0, checks = 0, now = 0, t0;
    logic [7:0] offs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14,
        8'h18, 8'h40};

    ctsu_top i_ctsu_top (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .ref_osc_clk(ref_clk), .sense_osc_clk(sense_clk),
        .ref_osc_en(ref_en), .sense_osc_en(sense_en), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .gpio_out(gout),
        .gpio_oe(goe), .gpio_in(gin), .touch_irq_req(irq_req),
        .touch_irq(irq));
    ctsu_pad_model i_ctsu_pad_model (.ref_osc_en(ref_en),
        .sense_osc_en(sense_en), .pad_out(pad_out), .pad_oe(pad_oe),
        .ref_osc_clk(ref_clk), .sense_osc_clk(sense_clk), .pad_in(pad_in));

    initial forever #10 sys_clk = ~sys_clk;
    always @(posedge sys_clk) now <= now + 1;

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task automatic test_done;
        $display("comparisons %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle, held until ack is sampled high
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
        if (n >= 50) chk("bus ack", 32'h0, 32'h1);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        xfer(1'b0, a, 32'h0);
        v = q;
    endtask
    task automatic rdc(input string nm, input logic [7:0] a,
        input logic [31:0] e);
        logic [31:0] v;
        rd(a, v);
        chk(nm, v, e);
    endtask
    task automatic inr(input string nm, input logic [7:0] a, int lo, hi);
        logic [31:0] v;
        rd(a, v);
        chk(nm, {31'h0, (v >= lo && v <= hi)}, 32'h1);
    endtask
    // waits for the request flag, returns cycles since t0
    task automatic wait_irq(output int dt);
        int n;
        n = 0;
        while (irq_req !== 1'b1 && n < 1000) begin
            @(posedge sys_clk);
            n++;
        end
        if (n >= 1000) chk("irq wait", 32'h0, 32'h1);
        dt = now - t0;
    endtask
    task automatic waitc(int n);
        repeat (n) @(posedge sys_clk);
    endtask

    initial begin
        #(20 * 30000);
        fail_count++;
        test_done;
    end

    initial begin
        int dt;
        waitc(6);
        rst <= 1'b0;
        // ----------------------------------------
        // reset values and unmapped space
        // ----------------------------------------
        foreach (offs[i]) rdc("reset value", offs[i], 32'h0);
        wr(8'h40, 32'hff);
        rdc("unmapped", 8'h40, 32'h0);
        wr(8'h00, 32'hff);
        rdc("pin ctrl mask", 8'h00, 32'hb3);
        $display("test registers done");
        // ----------------------------------------
        // pin routing
        // ----------------------------------------
        wr(8'h00, 32'h00);
        goe <= 2'b11;
        gout <= 2'b10;
        waitc(8);
        chk("pad_oe io", {30'h0, pad_oe}, 32'h3);
        chk("pad_out io", {30'h0, pad_out}, 32'h2);
        chk("gpio_in io", {30'h0, gin}, 32'h2);
        wr(8'h00, 32'h03);
        waitc(8);
        chk("pad_oe touch", {30'h0, pad_oe}, 32'h0);
        chk("gpio_in touch", {30'h0, gin}, 32'h3);
        goe <= 2'b00;
        $display("test routing done");
        // ----------------------------------------
        // scan on clock/4: (256-0xfe)*32*4 cycles
        // ----------------------------------------
        wr(8'h08, 32'h05);
        wr(8'h0c, 32'hfe);
        wr(8'h00, 32'h93);
        wr(8'h04, 32'h01);
        t0 = now;
        waitc(60);
        chk("ref en off", {31'h0, ref_en}, 32'h0);
        chk("sense en on", {30'h0, sense_en}, 32'h3);
        inr("pad1 count", 8'h10, 5, 20);
        inr("pad2 count", 8'h14, 3, 15);
        inr("func count", 8'h18, 5, 22);
        wait_irq(dt);
        chk("sys4 window", {31'h0, (dt >= 250 && dt <= 272)}, 32'h1);
        waitc(2);
        chk("irq level", {31'h0, irq}, 32'h1);
        chk("osc stopped", {29'h0, ref_en, sense_en}, 32'h0);
        rdc("slot cleared", 8'h0c, 32'h0);
        rdc("pad1 cleared", 8'h10, 32'h0);
        rdc("func cleared", 8'h18, 32'h0);
        rdc("irq flag", 8'h08, 32'h25);
        waitc(50);
        rdc("slot flag kept", 8'h04, 32'h05);
        $display("test scan clock4 done");
        // ----------------------------------------
        // clearing flags and aborting a scan
        // ----------------------------------------
        wr(8'h04, 32'h00);
        rdc("flags cleared", 8'h04, 32'h0);
        wr(8'h08, 32'h05);
        rdc("irq cleared", 8'h08, 32'h05);
        chk("irq req low", {31'h0, irq_req}, 32'h0);
        wr(8'h0c, 32'hfe);
        wr(8'h04, 32'h01);
        waitc(100);
        wr(8'h04, 32'h00);
        rdc("slot kept", 8'h0c, 32'hfe);
        rdc("pad1 held", 8'h10, 32'h0);
        chk("no irq abort", {31'h0, irq_req}, 32'h0);
        $display("test abort done");
        // ----------------------------------------
        // reference scan, pad 2 in I/O, mux on pad 2
        // ----------------------------------------
        wr(8'h0c, 32'hff);
        wr(8'h00, 32'h31);
        wr(8'h04, 32'h03);
        t0 = now;
        waitc(100);
        chk("ref en on", {31'h0, ref_en}, 32'h1);
        inr("pad1 runs", 8'h10, 3, 20);
        rdc("pad2 idle", 8'h14, 32'h0);
        rdc("func on pad2", 8'h18, 32'h0);
        wait_irq(dt);
        chk("ref window", {31'h0, (dt >= 300 && dt <= 345)}, 32'h1);
        waitc(2);
        rdc("scan flags", 8'h04, 32'h07);
        wr(8'h04, 32'h00);
        wr(8'h08, 32'h21);
        chk("irq masked", {31'h0, irq}, 32'h0);
        chk("req kept", {31'h0, irq_req}, 32'h1);
        $display("test ref scan done");
        test_done;
    end
endmodule

// *** common/ctsu_pkg.sv ***
// constants and state types for the capacitive touch scan unit
//
// How it works
// - slot clock is reference oscillator when select bit 7 is 0, else clock/4.
// - reference oscillator runs only with bit 5 set, sense oscillators with bit 4.
// - pad 2 pin is plain I/O when bit 1 is 0, touch input when 1.
// - pad 1 pin is plain I/O when bit 0 is 0, touch input when 1.
// - bits 6, 3 and 2 of pin control read as zero.
// - start low clears all three 16-bit counters and unit counter; slot counter kept.
// - rising start launches all four counters with oscillators synchronised.
// - slot overflow stops the oscillators and switches all four counters off.
// - slot overflow raises one touch interrupt request for all enabled pads.
// - slot overflow clears all three 16-bit counters, unit counter and slot counter.
// - slot overflow flag is set by hardware, cleared only by software.
// - either pad counter overflowing sets the sticky counter overflow flag.
// - function counter overflowing sets its sticky flag; software clears it.
// - each pad has its own independent sense oscillator.
// - sense cycles counted within the window are the result software reads; slot overflow clears them at window end.
// - only pads in touch mode take part in the scan.
// - slot overflow sets the touch interrupt request flag, bit 5.
// - mux select 0 routes pad 1 to the function counter, 1 routes pad 2.
package ctsu_pkg;

    // ------------------------------------------------------------
    // bus and register map
    // ------------------------------------------------------------
    localparam int CTSU_ADR_W = 8;
    localparam logic [7:0] CTSU_OFF_PIN_CTRL = 8'h00;
    localparam logic [7:0] CTSU_OFF_SCAN_CTRL = 8'h04;
    localparam logic [7:0] CTSU_OFF_IRQ_CTRL = 8'h08;
    localparam logic [7:0] CTSU_OFF_SLOT = 8'h0c;
    localparam logic [7:0] CTSU_OFF_CF1 = 8'h10;
    localparam logic [7:0] CTSU_OFF_CF2 = 8'h14;
    localparam logic [7:0] CTSU_OFF_FUNC = 8'h18;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int CTSU_PIN_SLOT_SEL = 7;
    localparam int CTSU_PIN_REF_EN = 5;
    localparam int CTSU_PIN_SENSE_EN = 4;
    localparam int CTSU_PIN_P2_FUNC = 1;
    localparam int CTSU_PIN_P1_FUNC = 0;
    localparam logic [7:0] CTSU_PIN_WMASK = 8'hb3;
    localparam logic [7:0] CTSU_PIN_RESET = 8'h00;

    localparam int CTSU_SC_START = 0;
    localparam int CTSU_SC_MUX = 1;
    localparam int CTSU_SC_SLOT_OVF = 2;
    localparam int CTSU_SC_CF_OVF = 3;
    localparam int CTSU_SC_FUNC_OVF = 4;

    localparam int CTSU_IRQ_GIE = 0;
    localparam int CTSU_IRQ_EN = 2;
    localparam int CTSU_IRQ_REQ = 5;

    // ------------------------------------------------------------
    // counter widths and timing counts
    // ------------------------------------------------------------
    localparam int CTSU_CNT_W = 16;
    localparam int CTSU_UNIT_W = 5;
    localparam int CTSU_SLOT_W = 8;
    localparam logic [1:0] CTSU_DIV_LAST = 2'h3;
    localparam int CTSU_PADS = 2;

    typedef struct packed {
        logic [7:0] pin_ctrl;
        logic scan_start;
        logic start_prev;
        logic key_mux;
        logic slot_ovf;
        logic cf_ovf;
        logic func_ovf;
        logic irq_req;
        logic irq_en;
        logic gie;
        logic running;
        logic [1:0] div;
        logic [CTSU_UNIT_W-1:0] unit;
        logic [CTSU_SLOT_W-1:0] slot;
        logic ack;
        logic [31:0] rdata;
        logic [CTSU_PADS-1:0] pad_out;
        logic [CTSU_PADS-1:0] pad_oe;
    } ctsu_top_s;

endpackage

// *** logic/ctsu_counter.sv ***
// scan counter with clear priority and wrap pulse
`timescale 1ns/1ps
module ctsu_counter
    import ctsu_pkg::*;
#(
    parameter int W = CTSU_CNT_W
)
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clr,
    input wire logic inc,
    output logic [W-1:0] count,
    output logic wrap
);

    typedef struct packed {
        logic [W-1:0] cnt;
    } ctsu_cnt_s;

    ctsu_cnt_s cnt_reg;
    ctsu_cnt_s cnt_next;

    generate
        if (W < 2 || W > 31) begin : g_bad_w
            $error("ctsu_counter width out of range");
        end
    endgenerate

    always_comb begin
        cnt_next = cnt_reg;
        if (clr) begin
            cnt_next.cnt = '0;
        end else if (inc) begin
            cnt_next.cnt = cnt_reg.cnt + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    assign count = cnt_reg.cnt;
    // wrap flagged even when cleared in the same cycle
    assign wrap = inc & (&cnt_reg.cnt);

endmodule

// *** logic/ctsu_sync.sv ***
// three-stage synchroniser with agreement filter and rise pulse
`timescale 1ns/1ps
module ctsu_sync
    import ctsu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic async_in,
    output logic level,
    output logic rise
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
        logic rise;
    } ctsu_sync_s;

    ctsu_sync_s sync_reg;
    ctsu_sync_s sync_next;

    // s1 feeds s2 only; the filter looks at s2 and s3
    always_comb begin
        sync_next = sync_reg;
        sync_next.s1 = async_in;
        sync_next.s2 = sync_reg.s1;
        sync_next.s3 = sync_reg.s2;
        sync_next.rise = 1'b0;
        if (sync_reg.s2 == sync_reg.s3) begin
            sync_next.lvl = sync_reg.s3;
            sync_next.rise = sync_reg.s3 & ~sync_reg.lvl;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync_reg <= '0;
        end else begin
            sync_reg <= sync_next;
        end
    end

    assign level = sync_reg.lvl;
    assign rise = sync_reg.rise;

endmodule

// *** logic/ctsu_top.sv ***
// touch scan unit: registers, slot timing, pad routing and counters
//
// The register offsets and the Wishbone slave port were decided locally.
`timescale 1ns/1ps
module ctsu_top
    import ctsu_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [CTSU_ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic ref_osc_clk,
    input wire logic [CTSU_PADS-1:0] sense_osc_clk,
    output logic ref_osc_en,
    output logic [CTSU_PADS-1:0] sense_osc_en,
    input wire logic [CTSU_PADS-1:0] pad_in,
    output logic [CTSU_PADS-1:0] pad_out,
    output logic [CTSU_PADS-1:0] pad_oe,
    input wire logic [CTSU_PADS-1:0] gpio_out,
    input wire logic [CTSU_PADS-1:0] gpio_oe,
    output logic [CTSU_PADS-1:0] gpio_in,
    output logic touch_irq_req,
    output logic touch_irq
);

    localparam logic [CTSU_UNIT_W-1:0] UNIT_MAX = '1;
    localparam logic [CTSU_SLOT_W-1:0] SLOT_MAX = '1;

    ctsu_top_s r;
    ctsu_top_s n;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic ref_rise;
    logic [CTSU_PADS-1:0] key_rise;
    logic [CTSU_PADS-1:0] pad_level;

    ctsu_sync u_ref_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .async_in(ref_osc_clk),
        .level(),
        .rise(ref_rise)
    );

    // oscillators must stay well under a quarter of sys_clk to be counted
    genvar gi;
    generate
        for (gi = 0; gi < CTSU_PADS; gi++) begin : g_pad_sync
            ctsu_sync u_key_sync (
                .sys_clk(sys_clk),
                .rst(rst),
                .async_in(sense_osc_clk[gi]),
                .level(),
                .rise(key_rise[gi])
            );
            ctsu_sync u_pin_sync (
                .sys_clk(sys_clk),
                .rst(rst),
                .async_in(pad_in[gi]),
                .level(pad_level[gi]),
                .rise()
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    function automatic logic is_reg(
        input logic [CTSU_ADR_W-1:0] adr,
        input logic [7:0] off
    );
        is_reg = (adr == off[CTSU_ADR_W-1:0]);
    endfunction

    logic wb_req;
    logic wb_wr;
    logic wr_byte0;
    assign wb_req = wb_cyc_i & wb_stb_i;
    assign wb_wr = wb_req & wb_we_i & ~r.ack;
    assign wr_byte0 = wb_wr & wb_sel_i[0];

    // ------------------------------------------------------------
    // slot timing and counter control
    // ------------------------------------------------------------
    logic [CTSU_PADS-1:0] pad_touch;
    logic start_rise;
    logic tick;
    logic unit_wrap;
    logic slot_wrap;
    logic cnt_clr;
    logic [CTSU_PADS-1:0] cf_inc;
    logic [CTSU_PADS-1:0] cf_wrap;
    logic [CTSU_CNT_W-1:0] cf_count [CTSU_PADS];
    logic func_inc;
    logic func_wrap;
    logic [CTSU_CNT_W-1:0] func_count;

    assign pad_touch[0] = r.pin_ctrl[CTSU_PIN_P1_FUNC];
    assign pad_touch[1] = r.pin_ctrl[CTSU_PIN_P2_FUNC];
    assign start_rise = r.scan_start & ~r.start_prev;
    // one step per source period; a start cleared in the same cycle
    // must not let a wrap pulse through that the branch below ignores
    assign tick = r.running & r.scan_start
        & (r.pin_ctrl[CTSU_PIN_SLOT_SEL] ?
        (r.div == CTSU_DIV_LAST) : ref_rise);
    assign unit_wrap = tick & (r.unit == UNIT_MAX);
    assign slot_wrap = unit_wrap & (r.slot == SLOT_MAX);
    assign cnt_clr = ~r.scan_start | start_rise | slot_wrap;

    // oscillators run only inside a window
    assign ref_osc_en = r.pin_ctrl[CTSU_PIN_REF_EN] & r.running;
    assign sense_osc_en = {CTSU_PADS{r.pin_ctrl[CTSU_PIN_SENSE_EN]
        & r.running}} & pad_touch;

    generate
        for (gi = 0; gi < CTSU_PADS; gi++) begin : g_cf
            assign cf_inc[gi] = sense_osc_en[gi] & key_rise[gi];
            ctsu_counter #(
                .W(CTSU_CNT_W)
            ) u_cf (
                .sys_clk(sys_clk),
                .rst(rst),
                .clr(cnt_clr),
                .inc(cf_inc[gi]),
                .count(cf_count[gi]),
                .wrap(cf_wrap[gi])
            );
        end
    endgenerate

    assign func_inc = r.key_mux ? cf_inc[1] : cf_inc[0];

    ctsu_counter #(
        .W(CTSU_CNT_W)
    ) u_func (
        .sys_clk(sys_clk),
        .rst(rst),
        .clr(cnt_clr),
        .inc(func_inc),
        .count(func_count),
        .wrap(func_wrap)
    );

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        if (is_reg(wb_adr_i, CTSU_OFF_PIN_CTRL)) begin
            rd_val[7:0] = r.pin_ctrl & CTSU_PIN_WMASK;
        end else if (is_reg(wb_adr_i, CTSU_OFF_SCAN_CTRL)) begin
            rd_val[CTSU_SC_START] = r.scan_start;
            rd_val[CTSU_SC_MUX] = r.key_mux;
            rd_val[CTSU_SC_SLOT_OVF] = r.slot_ovf;
            rd_val[CTSU_SC_CF_OVF] = r.cf_ovf;
            rd_val[CTSU_SC_FUNC_OVF] = r.func_ovf;
        end else if (is_reg(wb_adr_i, CTSU_OFF_IRQ_CTRL)) begin
            rd_val[CTSU_IRQ_GIE] = r.gie;
            rd_val[CTSU_IRQ_EN] = r.irq_en;
            rd_val[CTSU_IRQ_REQ] = r.irq_req;
        end else if (is_reg(wb_adr_i, CTSU_OFF_SLOT)) begin
            rd_val[CTSU_SLOT_W-1:0] = r.slot;
        end else if (is_reg(wb_adr_i, CTSU_OFF_CF1)) begin
            rd_val[CTSU_CNT_W-1:0] = cf_count[0];
        end else if (is_reg(wb_adr_i, CTSU_OFF_CF2)) begin
            rd_val[CTSU_CNT_W-1:0] = cf_count[1];
        end else if (is_reg(wb_adr_i, CTSU_OFF_FUNC)) begin
            rd_val[CTSU_CNT_W-1:0] = func_count;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.ack = wb_req & ~r.ack;
        if (wb_req & ~r.ack) begin
            n.rdata = rd_val;
        end
        n.start_prev = r.scan_start;

        // software writes; flags clear on a written zero
        if (wr_byte0 && is_reg(wb_adr_i, CTSU_OFF_PIN_CTRL)) begin
            n.pin_ctrl = wb_dat_i[7:0] & CTSU_PIN_WMASK;
        end
        if (wr_byte0 && is_reg(wb_adr_i, CTSU_OFF_SCAN_CTRL)) begin
            n.scan_start = wb_dat_i[CTSU_SC_START];
            n.key_mux = wb_dat_i[CTSU_SC_MUX];
            n.slot_ovf = r.slot_ovf & wb_dat_i[CTSU_SC_SLOT_OVF];
            n.cf_ovf = r.cf_ovf & wb_dat_i[CTSU_SC_CF_OVF];
            n.func_ovf = r.func_ovf & wb_dat_i[CTSU_SC_FUNC_OVF];
        end
        if (wr_byte0 && is_reg(wb_adr_i, CTSU_OFF_IRQ_CTRL)) begin
            n.gie = wb_dat_i[CTSU_IRQ_GIE];
            n.irq_en = wb_dat_i[CTSU_IRQ_EN];
            n.irq_req = r.irq_req & wb_dat_i[CTSU_IRQ_REQ];
        end
        // preset of the window length
        if (wr_byte0 && is_reg(wb_adr_i, CTSU_OFF_SLOT)) begin
            n.slot = wb_dat_i[CTSU_SLOT_W-1:0];
        end

        // divider restarts with each scan so the window is aligned
        n.div = r.running ? r.div + 2'h1 : 2'h0;

        if (!r.scan_start) begin
            n.running = 1'b0;
            n.unit = '0;
        end else if (start_rise) begin
            n.running = 1'b1;
            n.unit = '0;
            n.div = 2'h0;
        end else if (tick) begin
            n.unit = r.unit + 1'b1;
            if (unit_wrap) begin
                n.slot = r.slot + 1'b1;
            end
            if (slot_wrap) begin
                n.running = 1'b0;
                n.slot = '0;
                n.unit = '0;
                n.slot_ovf = 1'b1;
                n.irq_req = 1'b1;
            end
        end

        // sets after clears so an event is never lost
        if (|cf_wrap) begin
            n.cf_ovf = 1'b1;
        end
        if (func_wrap) begin
            n.func_ovf = 1'b1;
        end

        // touch mode takes the pin off the I/O driver
        n.pad_out = gpio_out;
        n.pad_oe = gpio_oe & ~pad_touch;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.rdata;
    assign pad_out = r.pad_out;
    assign pad_oe = r.pad_oe;
    assign gpio_in = pad_level;
    assign touch_irq_req = r.irq_req;
    assign touch_irq = r.irq_req & r.irq_en & r.gie;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);

    sequence seq_unit_wrap;
        unit_wrap && (r.slot != SLOT_MAX);
    endsequence

    sequence seq_window_end;
        slot_wrap ##1 (!r.running && r.slot == '0 && r.unit == '0);
    endsequence

    logic scan_wr;
    assign scan_wr = wr_byte0 && is_reg(wb_adr_i, CTSU_OFF_SCAN_CTRL);

    div_source_a: assert property (
        r.running && r.pin_ctrl[CTSU_PIN_SLOT_SEL] && r.scan_start
        && !start_rise && r.div != CTSU_DIV_LAST |=> $stable(r.unit))
        else $error("unit counter moved off the clock/4 tick");

    osc_gate_a: assert property (
        (ref_osc_en |-> r.pin_ctrl[CTSU_PIN_REF_EN])
        and (|sense_osc_en |-> r.pin_ctrl[CTSU_PIN_SENSE_EN]))
        else $error("oscillator enabled without its control bit");

    pad_mode_a: assert property (
        (r.pin_ctrl[CTSU_PIN_P2_FUNC] |=> !pad_oe[1])
        and (!r.pin_ctrl[CTSU_PIN_P2_FUNC]
        |=> pad_oe[1] == $past(gpio_oe[1])))
        else $error("pad two driven while in touch mode");

    pad_one_a: assert property (
        r.pin_ctrl[CTSU_PIN_P1_FUNC] |=> !pad_oe[0])
        else $error("pad one driven while in touch mode");

    reserved_zero_a: assert property (
        wb_req && !r.ack && !wb_we_i
        && is_reg(wb_adr_i, CTSU_OFF_PIN_CTRL)
        |=> wb_ack_o && wb_dat_o[6] == 1'b0 && wb_dat_o[3:2] == 2'h0)
        else $error("reserved pin control bits read nonzero");

    idle_clear_a: assert property (
        !r.scan_start && !wb_wr |=> r.unit == '0 && cf_count[0] == '0
        && func_count == '0 && $stable(r.slot))
        else $error("idle scan did not clear counters or moved slot");

    start_run_a: assert property (
        start_rise |=> r.running && r.unit == '0 && r.div == 2'h0)
        else $error("rising start did not launch the scan");

    window_end_a: assert property (
        slot_wrap |-> seq_window_end)
        else $error("scan kept running after slot overflow");

    overflow_clear_a: assert property (
        slot_wrap |=> cf_count[0] == '0 && cf_count[1] == '0
        && func_count == '0 ##1 !ref_osc_en)
        else $error("counters not cleared at slot overflow");

    irq_set_a: assert property (
        slot_wrap |=> r.irq_req && touch_irq_req && r.slot_ovf)
        else $error("slot overflow did not raise the request");

    slot_sticky_a: assert property (
        r.slot_ovf && !scan_wr |=> r.slot_ovf)
        else $error("slot overflow flag dropped by itself");

    cf_flag_a: assert property (
        (|cf_wrap) |=> r.cf_ovf ##1 (r.cf_ovf || $past(scan_wr)))
        else $error("counter overflow flag not held");

    func_flag_a: assert property (
        func_wrap |=> r.func_ovf)
        else $error("function overflow flag not set");

    slot_step_a: assert property (
        seq_unit_wrap and !wb_wr |=> r.slot == $past(r.slot) + 1'b1)
        else $error("slot counter did not step on unit wrap");

endmodule
